// [sim/prsd_board.sv]
`timescale 1ns/100ps
module prsd_board
(
   input wire logic [3:0] plat_sel,
   input wire logic [1:0] core_sel,
   output logic [3:0] plat,
   output logic hi,
   output logic lo
);
   assign plat = plat_sel;
   assign {hi, lo} = core_sel;
endmodule

// [sim/prsd_properties.sv]
`timescale 1ns/100ps
module prsd_checker
(
   input wire logic CLOCK,
   input wire logic RST,
   input wire prsd_pkg::prsd_plat_t PLATFORM_RATIO_STRAP,
   input wire logic CORE_RATIO_STRAP_HI,
   input wire logic CORE_RATIO_STRAP_LO,
   input wire logic [4:0] PLATFORM_BUS_CLOCK_MULT,
   input wire logic [2:0] CORE_RATIO_HALF,
   input wire logic [3:0] PLATFORM_CODE,
   input wire logic [1:0] CORE_CODE,
   input wire logic RATIO_INVALID,
   input wire logic RATIO_VALID
);
   wire logic done = RATIO_VALID | RATIO_INVALID;
   wire logic [5:0] pins = {CORE_RATIO_STRAP_HI, CORE_RATIO_STRAP_LO,
      PLATFORM_RATIO_STRAP};
   wire logic [16:0] outs = {PLATFORM_BUS_CLOCK_MULT, CORE_RATIO_HALF,
      PLATFORM_CODE, CORE_CODE, RATIO_VALID, RATIO_INVALID};
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RST);
   property p_lat; $fell(RST) |-> !done[*4] ##1 done; endproperty
   a_lat: assert property (p_lat) else $error("late flags");
   property p_cap;
      $fell(RST) |-> ##4 {CORE_CODE, PLATFORM_CODE} == $past(pins, 4);
   endproperty
   a_cap: assert property (p_cap) else $error("bad capture");
   property p_hold; done |=> $stable(outs); endproperty
   a_hold: assert property (p_hold) else $error("moved");
   property p_x16;
      RATIO_VALID && PLATFORM_CODE == 4'h0 |->
         PLATFORM_BUS_CLOCK_MULT == 5'h10;
   endproperty
   a_x16: assert property (p_x16) else $error("bad x16");
   property p_lo;
      RATIO_VALID && PLATFORM_CODE inside {[4'h2:4'h6]} |->
         PLATFORM_BUS_CLOCK_MULT == {1'b0, PLATFORM_CODE};
   endproperty
   a_lo: assert property (p_lo) else $error("bad low mult");
   property p_hi;
      RATIO_VALID && PLATFORM_CODE inside {4'h8, 4'h9, 4'hA, 4'hC} |->
         PLATFORM_BUS_CLOCK_MULT == {1'b0, PLATFORM_CODE};
   endproperty
   a_hi: assert property (p_hi) else $error("bad high mult");
   property p_bad;
      done |-> RATIO_VALID ^ RATIO_INVALID && RATIO_INVALID ==
         (PLATFORM_CODE inside {4'h1, 4'h7, 4'hB, [4'hD:4'hF]});
   endproperty
   a_bad: assert property (p_bad) else $error("bad flag");
   property p_core; done |-> CORE_RATIO_HALF == {1'b1, CORE_CODE}; endproperty
   a_core: assert property (p_core) else $error("bad core");
endmodule
bind prsd_strap_top prsd_checker u_chk (.CLOCK(CLOCK), .RST(RST),
   .PLATFORM_RATIO_STRAP(PLATFORM_RATIO_STRAP),
   .CORE_RATIO_STRAP_HI(CORE_RATIO_STRAP_HI),
   .CORE_RATIO_STRAP_LO(CORE_RATIO_STRAP_LO),
   .PLATFORM_BUS_CLOCK_MULT(PLATFORM_BUS_CLOCK_MULT),
   .CORE_RATIO_HALF(CORE_RATIO_HALF), .PLATFORM_CODE(PLATFORM_CODE),
   .CORE_CODE(CORE_CODE), .RATIO_INVALID(RATIO_INVALID),
   .RATIO_VALID(RATIO_VALID));

// [sim/testbench.sv]
`timescale 1ns/100ps
module testbench;
   import prsd_pkg::*;
   logic CLOCK = 1'b0;
   logic RST = 1'b1;
   logic [3:0] psel = 4'h0;
   logic [1:0] csel = 2'h0;
   wire logic [3:0] plat, pcode;
   wire logic [1:0] ccode;
   wire logic [4:0] mult;
   wire logic [2:0] half;
   wire logic hi, lo, inv, ok;
   int failures = 0;
   int checked = 0;
   prsd_board u_board (.plat_sel(psel), .core_sel(csel), .plat(plat),
      .hi(hi), .lo(lo));
   prsd_strap_top u_dut (.CLOCK(CLOCK), .RST(RST),
      .PLATFORM_RATIO_STRAP(plat), .CORE_RATIO_STRAP_HI(hi),
      .CORE_RATIO_STRAP_LO(lo), .PLATFORM_BUS_CLOCK_MULT(mult),
      .CORE_RATIO_HALF(half), .PLATFORM_CODE(pcode), .CORE_CODE(ccode),
      .RATIO_INVALID(inv), .RATIO_VALID(ok));
   initial forever #25 CLOCK = ~CLOCK;
   task automatic wrap_up();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(string n, logic [4:0] e, logic [4:0] g);
      checked++;
      if (g !== e)
      begin
         $display("BAD %s expected %h seen %h", n, e, g);
         failures++;
      end
   endtask
   function automatic logic [4:0] exp_m(logic [3:0] p);
      case (p)
         4'h0: exp_m = 5'h10;
         4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA, 4'hC:
            exp_m = {1'b0, p};
         default: exp_m = 5'h00;
      endcase
   endfunction
   // Straps settle three edges before release, beyond the two required
   task automatic boot(logic [3:0] p, logic [1:0] c);
      int n;
      @(posedge CLOCK);
      psel <= p;
      csel <= c;
      RST <= 1'b1;
      repeat (3) @(posedge CLOCK);
      RST <= 1'b0;
      n = 0;
      while ((ok | inv) !== 1'b1 && n < 9)
      begin
         @(posedge CLOCK);
         #1;
         n++;
      end
      if (n == 9)
      begin
         failures++;
         wrap_up();
      end
      chk("latency", 5'h04, 5'(n));
   endtask
   task automatic t_plat();
      for (int i = 0; i < 16; i++)
      begin
         boot(i[3:0], 2'h0);
         chk("mult", exp_m(i[3:0]), mult);
         chk("invalid", 5'(exp_m(i[3:0]) == 5'h00), 5'(inv));
         chk("valid", 5'(exp_m(i[3:0]) != 5'h00), 5'(ok));
         chk("pcode", 5'(i[3:0]), 5'(pcode));
      end
      $display("t_plat done");
   endtask
   task automatic t_core();
      for (int c = 0; c < 4; c++)
      begin
         boot(4'h4, c[1:0]);
         chk("half", 5'({1'b1, c[1:0]}), 5'(half));
         chk("ccode", 5'(c[1:0]), 5'(ccode));
      end
      $display("t_core done");
   endtask
   // Later strap activity must never reach the ratios
   task automatic t_hold();
      boot(4'h9, 2'h2);
      @(posedge CLOCK);
      psel <= 4'h3;
      csel <= 2'h1;
      repeat (6) @(posedge CLOCK);
      #1;
      chk("held mult", 5'h09, mult);
      chk("held half", 5'h06, 5'(half));
      $display("t_hold done");
   endtask
   initial
   begin
      repeat (16) @(posedge CLOCK);
      t_plat();
      t_core();
      t_hold();
      wrap_up();
   end
endmodule

// [src/prsd_cfg_if.sv]
`timescale 1ns/100ps
interface prsd_cfg_if;
   import prsd_pkg::*;
   logic [PRSD_PLAT_W-1:0] plat_code;
   logic [PRSD_CORE_W-1:0] core_code;
   logic [PRSD_MULT_W-1:0] plat_mult;
   logic [PRSD_HALF_W-1:0] core_half;
   logic plat_bad;
   modport top (output plat_code, output core_code,
                input plat_mult, input core_half, input plat_bad);
   modport dec (input plat_code, input core_code,
                output plat_mult, output core_half, output plat_bad);
endinterface

// [src/prsd_pkg.sv]
package prsd_pkg;
   localparam int PRSD_PLAT_W = 4;
   localparam int PRSD_CORE_W = 2;
   localparam int PRSD_MULT_W = 5;
   localparam int PRSD_HALF_W = 3;
   typedef logic [PRSD_PLAT_W-1:0] prsd_plat_t;
   typedef logic [PRSD_CORE_W-1:0] prsd_core_t;
   typedef logic [PRSD_MULT_W-1:0] prsd_mult_t;
   typedef logic [PRSD_HALF_W-1:0] prsd_half_t;
   // Platform strap codes
   localparam prsd_plat_t PRSD_P_X16 = 4'h0;
   localparam prsd_plat_t PRSD_P_X2 = 4'h2;
   localparam prsd_plat_t PRSD_P_X3 = 4'h3;
   localparam prsd_plat_t PRSD_P_X4 = 4'h4;
   localparam prsd_plat_t PRSD_P_X5 = 4'h5;
   localparam prsd_plat_t PRSD_P_X6 = 4'h6;
   localparam prsd_plat_t PRSD_P_X8 = 4'h8;
   localparam prsd_plat_t PRSD_P_X9 = 4'h9;
   localparam prsd_plat_t PRSD_P_X10 = 4'hA;
   localparam prsd_plat_t PRSD_P_X12 = 4'hC;
   // Platform multipliers
   localparam prsd_mult_t PRSD_M16 = 5'h10;
   localparam prsd_mult_t PRSD_M2 = 5'h02;
   localparam prsd_mult_t PRSD_M3 = 5'h03;
   localparam prsd_mult_t PRSD_M4 = 5'h04;
   localparam prsd_mult_t PRSD_M5 = 5'h05;
   localparam prsd_mult_t PRSD_M6 = 5'h06;
   localparam prsd_mult_t PRSD_M8 = 5'h08;
   localparam prsd_mult_t PRSD_M9 = 5'h09;
   localparam prsd_mult_t PRSD_M10 = 5'h0A;
   localparam prsd_mult_t PRSD_M12 = 5'h0C;
   localparam prsd_mult_t PRSD_M_NONE = 5'h00;
   // Core ratio in half steps: 2:1 is 4, 5:2 is 5, 3:1 is 6, 7:2 is 7
   localparam prsd_core_t PRSD_C_2 = 2'h0;
   localparam prsd_core_t PRSD_C_25 = 2'h1;
   localparam prsd_core_t PRSD_C_3 = 2'h2;
   localparam prsd_core_t PRSD_C_35 = 2'h3;
   localparam prsd_half_t PRSD_H_2 = 3'h4;
   localparam prsd_half_t PRSD_H_25 = 3'h5;
   localparam prsd_half_t PRSD_H_3 = 3'h6;
   localparam prsd_half_t PRSD_H_35 = 3'h7;
   localparam prsd_half_t PRSD_H_NONE = 3'h0;
   // Settle cycles after reset release before the straps are captured
   localparam int PRSD_SYNC_CYC = 2;
   typedef enum logic [2:0]
   {
      PRSD_ST_RESET = 3'b001,
      PRSD_ST_SETTLE = 3'b010,
      PRSD_ST_HOLD = 3'b100
   } prsd_state_e;
endpackage

// [src/prsd_ratio_decode.sv]
`timescale 1ns/100ps
module prsd_ratio_decode
(
   prsd_cfg_if.dec cfg
);
   import prsd_pkg::*;

   always_comb
   begin
      cfg.plat_bad = 1'b0;
      case (cfg.plat_code)
         PRSD_P_X16: cfg.plat_mult = PRSD_M16;
         PRSD_P_X2: cfg.plat_mult = PRSD_M2;
         PRSD_P_X3: cfg.plat_mult = PRSD_M3;
         PRSD_P_X4: cfg.plat_mult = PRSD_M4;
         PRSD_P_X5: cfg.plat_mult = PRSD_M5;
         PRSD_P_X6: cfg.plat_mult = PRSD_M6;
         PRSD_P_X8: cfg.plat_mult = PRSD_M8;
         PRSD_P_X9: cfg.plat_mult = PRSD_M9;
         PRSD_P_X10: cfg.plat_mult = PRSD_M10;
         PRSD_P_X12: cfg.plat_mult = PRSD_M12;
         default:
         begin
            cfg.plat_mult = PRSD_M_NONE;
            cfg.plat_bad = 1'b1;
         end
      endcase
   end

   always_comb
   begin
      case (cfg.core_code)
         PRSD_C_2: cfg.core_half = PRSD_H_2;
         PRSD_C_25: cfg.core_half = PRSD_H_25;
         PRSD_C_3: cfg.core_half = PRSD_H_3;
         PRSD_C_35: cfg.core_half = PRSD_H_35;
         default: cfg.core_half = PRSD_H_NONE;
      endcase
   end
endmodule

// [src/prsd_strap_top.sv]
// Summary of operation
// - The decoded platform ratio is the one that clocks the level-2 cache, memory data rate and core complex bus.
// - At power-up the four platform ratio straps are sampled and their binary value picks the platform to reference ratio.
// - Platform code 0000 gives sixteen times the reference clock.
// - Platform codes 0010 to 0110 give two to six times the reference clock.
// - Platform codes 1000, 1001 and 1010 give eight, nine and ten times.
// - Platform code 1100 gives twelve times the reference clock.
// - At power-up the two core straps are sampled, high strap as upper bit, to pick the core ratio.
// - Core codes 00, 01, 10, 11 give 2:1, 5:2, 3:1 and 7:2.
`timescale 1ns/100ps
module prsd_strap_top
(
   input wire logic CLOCK,
   input wire logic RST,
   input wire prsd_pkg::prsd_plat_t PLATFORM_RATIO_STRAP,
   input wire logic CORE_RATIO_STRAP_HI,
   input wire logic CORE_RATIO_STRAP_LO,
   output logic [prsd_pkg::PRSD_MULT_W-1:0] PLATFORM_BUS_CLOCK_MULT,
   output logic [prsd_pkg::PRSD_HALF_W-1:0] CORE_RATIO_HALF,
   output logic [prsd_pkg::PRSD_PLAT_W-1:0] PLATFORM_CODE,
   output logic [prsd_pkg::PRSD_CORE_W-1:0] CORE_CODE,
   output logic RATIO_INVALID,
   output logic RATIO_VALID
);
   import prsd_pkg::*;

   localparam int SYNC_W = PRSD_PLAT_W + PRSD_CORE_W;

   logic [SYNC_W-1:0] strap_pins;
   logic [SYNC_W-1:0] meta_reg;
   logic [SYNC_W-1:0] sync_reg;
   prsd_state_e state_reg;
   prsd_state_e state_next;
   logic [1:0] settle_reg;
   logic [1:0] settle_next;
   logic capture;
   logic hold;
   logic load;
   logic loaded_reg;
   prsd_plat_t plat_code_reg;
   prsd_core_t core_code_reg;
   prsd_cfg_if cfg ();

   assign strap_pins = {PLATFORM_RATIO_STRAP, CORE_RATIO_STRAP_HI,
                        CORE_RATIO_STRAP_LO};

   // Straps are asynchronous pins; two stages per bit before any use
   for (genvar i = 0; i < SYNC_W; i++)
   begin : g_sync
      always_ff @(posedge CLOCK)
      begin
         meta_reg[i] <= strap_pins[i];
         sync_reg[i] <= meta_reg[i];
      end
   end

   // Let the synchroniser fill with post-reset strap levels
   always_comb
   begin
      if (state_reg == PRSD_ST_SETTLE)
         settle_next = settle_reg + 2'h1;
      else
         settle_next = 2'h0;
   end

   always_ff @(posedge CLOCK)
   begin
      if (RST)
         settle_reg <= 2'h0;
      else
         settle_reg <= settle_next;
   end

   // straps taken once, at the end of the settle count
   always_comb
   begin
      capture = 1'b0;
      if (state_reg == PRSD_ST_SETTLE)
      begin
         if (settle_reg == 2'(PRSD_SYNC_CYC - 1))
            capture = 1'b1;
      end
   end

   always_comb
   begin
      hold = 1'b0;
      if (state_reg == PRSD_ST_HOLD)
         hold = 1'b1;
   end

   // outputs load on the first hold cycle only, so nothing that
   // reaches the decoder later can move the pins
   always_comb
   begin
      load = 1'b0;
      if (hold && !loaded_reg)
         load = 1'b1;
   end

   always_ff @(posedge CLOCK)
   begin
      if (RST)
         loaded_reg <= 1'b0;
      else if (load)
         loaded_reg <= 1'b1;
   end

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         PRSD_ST_RESET:
         begin
            state_next = PRSD_ST_SETTLE;
         end
         PRSD_ST_SETTLE:
         begin
            if (capture)
               state_next = PRSD_ST_HOLD;
         end
         PRSD_ST_HOLD:
         begin
            // no way back short of reset
            state_next = PRSD_ST_HOLD;
         end
         default:
         begin
            state_next = PRSD_ST_RESET;
         end
      endcase
   end

   always_ff @(posedge CLOCK)
   begin
      if (RST)
         state_reg <= PRSD_ST_RESET;
      else
         state_reg <= state_next;
   end

   always_ff @(posedge CLOCK)
   begin
      if (RST)
         plat_code_reg <= PRSD_P_X16;
      else if (capture)
         plat_code_reg <= sync_reg[SYNC_W-1 -: PRSD_PLAT_W];
   end

   // core code is high then low
   always_ff @(posedge CLOCK)
   begin
      if (RST)
         core_code_reg <= PRSD_C_2;
      else if (capture)
         core_code_reg <= sync_reg[PRSD_CORE_W-1:0];
   end

   assign cfg.plat_code = plat_code_reg;
   assign cfg.core_code = core_code_reg;

   prsd_ratio_decode u_dec
   (
      .cfg(cfg)
   );

   always_ff @(posedge CLOCK)
   begin
      if (RST)
         PLATFORM_BUS_CLOCK_MULT <= PRSD_M_NONE;
      else if (load)
         PLATFORM_BUS_CLOCK_MULT <= cfg.plat_mult;
   end

   always_ff @(posedge CLOCK)
   begin
      if (RST)
         CORE_RATIO_HALF <= PRSD_H_NONE;
      else if (load)
         CORE_RATIO_HALF <= cfg.core_half;
   end

   always_ff @(posedge CLOCK)
   begin
      if (RST)
         PLATFORM_CODE <= PRSD_P_X16;
      else if (load)
         PLATFORM_CODE <= plat_code_reg;
   end

   always_ff @(posedge CLOCK)
   begin
      if (RST)
         CORE_CODE <= PRSD_C_2;
      else if (load)
         CORE_CODE <= core_code_reg;
   end

   always_ff @(posedge CLOCK)
   begin
      if (RST)
         RATIO_INVALID <= 1'b0;
      else if (load)
         RATIO_INVALID <= cfg.plat_bad;
   end

   always_ff @(posedge CLOCK)
   begin
      if (RST)
         RATIO_VALID <= 1'b0;
      else if (load)
         RATIO_VALID <= ~cfg.plat_bad;
   end
endmodule
